// file: adc_test_config_params.svh
// Offsets, field positions, reset values and pattern constants
// Assumes inclusion by the register bank; the package does not include it
// Summary of operation
// - Clock divide ratio is divider field plus one, reset zero
// - Chop bit one turns chop mode on, off after reset
// - Four-bit selector picks one of twelve output test patterns
// - Nonzero selector replaces converted samples with test data
// - Two-bit sequencing steers user pattern order, only in user mode
// - Long and short generator reset bits are global, rest per channel
// - Per-channel signed eight-bit offset trim added to samples
// - Format bit zero offset binary, one two's complement, default one
// - Per-channel invert bit inverts that channel's output data
// - Output standard bit selects normal or reduced-range signalling
// - User mode takes data from two sixteen-bit user pattern values
`ifndef ADC_TEST_CONFIG_PARAMS_SVH
`define ADC_TEST_CONFIG_PARAMS_SVH
`define ADDR_CLOCK_DIVIDER 8'h0b
`define ADDR_CHOP_CONTROL  8'h0c
`define ADDR_TEST_PATTERN  8'h0d
`define ADDR_OFFSET_TRIM   8'h10
`define ADDR_OUTPUT_FORMAT 8'h14
`define RESET_CLOCK_DIV    3'h0
`define RESET_FORMAT_REG   8'h01
`define BIT_CHOP           2
`define BIT_LONG_PRBS_RST  5
`define BIT_SHORT_PRBS_RST 4
`define BIT_INVERT         2
`define BIT_STANDARD       6
`define BIT_FORMAT         0
`define SEED_LONG_PRBS     23'h7fffff
`define SEED_SHORT_PRBS    9'h1ff
`define PAT_MIDSCALE       12'h800
`define PAT_FULL_POS       12'hfff
`define PAT_FULL_NEG       12'h000
`define PAT_CHECKER        12'haaa
`define PAT_SYNC           12'h03f
`define PAT_MIXED          12'ha0f
`define TRIM_MAX           12'h7ff
`define TRIM_MIN           12'h800
`endif

// file: adc_test_config_pkg.sv
// Types shared by the register bank and its surroundings
// Assumes the params header sits in the same folder
package adc_test_config_pkg;
	typedef enum logic [3:0]
	{
		TEST_OFF      = 4'h0,
		TEST_MIDSCALE = 4'h1,
		TEST_FULL_POS = 4'h2,
		TEST_FULL_NEG = 4'h3,
		TEST_CHECKER  = 4'h4,
		TEST_PN_LONG  = 4'h5,
		TEST_PN_SHORT = 4'h6,
		TEST_WORD_TOG = 4'h7,
		TEST_USER     = 4'h8,
		TEST_BIT_TOG  = 4'h9,
		TEST_SYNC     = 4'ha,
		TEST_ONE_HIGH = 4'hb,
		TEST_MIXED    = 4'hc
	} test_select_type;
	typedef enum logic [1:0]
	{
		SEQ_SINGLE         = 2'h0,
		SEQ_ALTERNATE      = 2'h1,
		SEQ_SINGLE_ONCE    = 2'h2,
		SEQ_ALTERNATE_ONCE = 2'h3
	} user_sequence_type;
	typedef logic [7:0][11:0] channel_words_type;
	typedef struct packed
	{
		logic [2:0] clockDivide;
		logic       chopEnable;
		logic       reducedRange;
		logic       twosComplement;
	} global_config_type;
	typedef struct packed
	{
		logic             write;
		logic [7:0]       address;
		logic [7:0]       writeData;
		logic [7:0]       channelSelect;
	} reg_request_type;
endpackage

// file: adc_output_test_config_regs.sv
// Configuration register bank with test pattern and output data path
// Assumes the serial port engine hands over decoded register accesses
`timescale 1ns/1ps
`default_nettype none
`include "adc_test_config_params.svh"
module adc_output_test_config_regs
	import adc_test_config_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic              softReset,
	input  wire reg_request_type   regRequest,
	output logic       [7:0]       regReadData,
	input  wire logic  [15:0]      userPattern1,
	input  wire logic  [15:0]      userPattern2,
	input  wire logic              sampleValid,
	input  wire channel_words_type sampleData,
	output var global_config_type  globalConfig,
	output logic                   dividedClockTick,
	output logic                   outValid,
	output var channel_words_type  outData
);
	typedef struct packed
	{
		global_config_type          cfg;
		logic                       longPrbsReset;
		logic                       shortPrbsReset;
		logic [7:0][3:0]            testSelect;
		logic [7:0][1:0]            userSequence;
		logic [7:0][1:0]            userStep;
		logic [7:0][7:0]            offsetTrim;
		logic [7:0]                 invert;
		logic [2:0]                 divideCount;
		logic                       divTick;
		logic                       frameToggle;
		logic [3:0]                 walkBit;
		logic [22:0]                longPrbs;
		logic [8:0]                 shortPrbs;
		logic                       valid;
		channel_words_type          data;
	} state_type;

	state_type state;
	state_type next_state;

	// Offset binary in, trimmed with saturation, then coded as asked
	function automatic logic [11:0] trimSample(input logic [11:0] raw,
		input logic [7:0] trim, input logic twos);
		logic [12:0] sum;
		logic [11:0] res;
		// Flipping the top bit turns offset binary into signed form
		sum = {~raw[11], ~raw[11], raw[10:0]} + {{5{trim[7]}}, trim};
		if (sum[12] != sum[11])
			res = sum[12] ? `TRIM_MIN : `TRIM_MAX;
		else
			res = sum[11:0];
		trimSample = twos ? res : {~res[11], res[10:0]};
	endfunction

	// User word choice for the current step of the sequence
	function automatic logic [11:0] userWord(input logic [1:0] seq,
		input logic [1:0] step, input logic [15:0] p1,
		input logic [15:0] p2);
		logic useSecond;
		logic done;
		useSecond = seq[0] & step[0];
		done = seq[1] & (seq[0] ? step[1] : |step);
		if (done)
			userWord = 12'h000;
		else
			userWord = useSecond ? p2[15:4] : p1[15:4];
	endfunction

	always_comb
	begin
		logic [7:0]  readBack;
		logic [2:0]  firstChannel;
		logic [11:0] pattern;
		readBack = 8'h00;
		firstChannel = 3'h0;
		pattern = 12'h000;
		next_state = state;
		next_state.valid = 1'b0;
		next_state.divTick = 1'b0;
		for (int c = 7; c >= 0; c--)
		begin
			if (regRequest.channelSelect[c])
				firstChannel = 3'(c);
		end
		if (state.divideCount >= state.cfg.clockDivide)
		begin
			next_state.divideCount = 3'h0;
			next_state.divTick = 1'b1;
		end
		else
			next_state.divideCount = state.divideCount + 3'h1;
		if (regRequest.write)
		begin
			case (regRequest.address)
			`ADDR_CLOCK_DIVIDER:
				next_state.cfg.clockDivide = regRequest.writeData[2:0];
			`ADDR_CHOP_CONTROL:
				next_state.cfg.chopEnable = regRequest.writeData[`BIT_CHOP];
			`ADDR_TEST_PATTERN:
			begin
				next_state.longPrbsReset =
					regRequest.writeData[`BIT_LONG_PRBS_RST];
				next_state.shortPrbsReset =
					regRequest.writeData[`BIT_SHORT_PRBS_RST];
				for (int c = 0; c < 8; c++)
				begin
					if (regRequest.channelSelect[c])
					begin
						next_state.testSelect[c] = regRequest.writeData[3:0];
						next_state.userSequence[c] =
							regRequest.writeData[7:6];
						next_state.userStep[c] = 2'h0;
					end
				end
			end
			`ADDR_OFFSET_TRIM:
			begin
				for (int c = 0; c < 8; c++)
				begin
					if (regRequest.channelSelect[c])
						next_state.offsetTrim[c] = regRequest.writeData;
				end
			end
			`ADDR_OUTPUT_FORMAT:
			begin
				next_state.cfg.twosComplement =
					regRequest.writeData[`BIT_FORMAT];
				next_state.cfg.reducedRange =
					regRequest.writeData[`BIT_STANDARD];
				for (int c = 0; c < 8; c++)
				begin
					if (regRequest.channelSelect[c])
						next_state.invert[c] =
							regRequest.writeData[`BIT_INVERT];
				end
			end
			default:
				readBack = 8'h00;
			endcase
		end
		case (regRequest.address)
		`ADDR_CLOCK_DIVIDER:
			readBack = {5'h00, state.cfg.clockDivide};
		`ADDR_CHOP_CONTROL:
			readBack = {5'h00, state.cfg.chopEnable, 2'h0};
		`ADDR_TEST_PATTERN:
			readBack = {state.userSequence[firstChannel],
				state.longPrbsReset, state.shortPrbsReset,
				state.testSelect[firstChannel]};
		`ADDR_OFFSET_TRIM:
			readBack = state.offsetTrim[firstChannel];
		`ADDR_OUTPUT_FORMAT:
			readBack = {1'b0, state.cfg.reducedRange, 3'h0,
				state.invert[firstChannel], 1'b0, state.cfg.twosComplement};
		default:
			readBack = 8'h00;
		endcase
		// Generators step once per frame; held at seed while reset bit set
		if (state.longPrbsReset)
			next_state.longPrbs = `SEED_LONG_PRBS;
		else if (sampleValid)
			next_state.longPrbs = {state.longPrbs[21:0],
				state.longPrbs[22] ^ state.longPrbs[17]};
		if (state.shortPrbsReset)
			next_state.shortPrbs = `SEED_SHORT_PRBS;
		else if (sampleValid)
			next_state.shortPrbs = {state.shortPrbs[7:0],
				state.shortPrbs[8] ^ state.shortPrbs[4]};
		// one word per channel per frame
		if (sampleValid)
		begin
			next_state.valid = 1'b1;
			next_state.frameToggle = ~state.frameToggle;
			next_state.walkBit = (state.walkBit == 4'hb) ? 4'h0 :
				state.walkBit + 4'h1;
			for (int c = 0; c < 8; c++)
			begin
				case (state.testSelect[c])
				TEST_MIDSCALE: pattern = `PAT_MIDSCALE;
				TEST_FULL_POS: pattern = `PAT_FULL_POS;
				TEST_FULL_NEG: pattern = `PAT_FULL_NEG;
				TEST_CHECKER:  pattern = state.frameToggle ?
					`PAT_CHECKER : ~`PAT_CHECKER;
				TEST_PN_LONG:  pattern = state.longPrbs[22:11];
				TEST_PN_SHORT: pattern = {state.shortPrbs, 3'h0};
				TEST_WORD_TOG: pattern = state.frameToggle ?
					`PAT_FULL_POS : `PAT_FULL_NEG;
				TEST_USER:     pattern = userWord(state.userSequence[c],
					state.userStep[c], userPattern1, userPattern2);
				TEST_BIT_TOG:  pattern = `PAT_CHECKER;
				TEST_SYNC:     pattern = `PAT_SYNC;
				TEST_ONE_HIGH: pattern = 12'h001 << state.walkBit;
				TEST_MIXED:    pattern = `PAT_MIXED;
				default:       pattern = 12'h000;
				endcase
				// sequence steps only in user mode; once modes stop
				// Repeating modes wrap the step, once modes park at three
				if (state.testSelect[c] == TEST_USER &&
					(!state.userSequence[c][1] || state.userStep[c] != 2'h3))
					next_state.userStep[c] = state.userStep[c] + 2'h1;
				if (state.testSelect[c] != TEST_OFF)
					next_state.data[c] = pattern;
				else
					next_state.data[c] = trimSample(sampleData[c],
						state.offsetTrim[c], state.cfg.twosComplement);
				if (state.invert[c])
					next_state.data[c] = ~next_state.data[c];
			end
		end
		regReadData = readBack;
	end

	// Soft reset shares the path so every field has one default
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || softReset)
		begin
			state <= '0;
			state.cfg.clockDivide <= `RESET_CLOCK_DIV;
			state.cfg.twosComplement <= 1'(`RESET_FORMAT_REG >> `BIT_FORMAT);
			state.longPrbs <= `SEED_LONG_PRBS;
			state.shortPrbs <= `SEED_SHORT_PRBS;
		end
		else
			state <= next_state;
	end

	assign globalConfig = state.cfg;
	assign dividedClockTick = state.divTick;
	assign outValid = state.valid;
	assign outData = state.data;
endmodule
`default_nettype wire

// file: config_regs_checker_sva.sv
// Assertion checker for the config register bank
// Assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module config_regs_checker
	import adc_test_config_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              reset_n,
	input wire logic              softReset,
	input wire reg_request_type   regRequest,
	input wire logic              sampleValid,
	input wire global_config_type globalConfig,
	input wire logic              dividedClockTick,
	input wire logic              outValid
);
	logic       wr;
	logic [7:0] adr;
	logic [7:0] wd;
	assign wr = regRequest.write && !softReset;
	assign adr = regRequest.address;
	assign wd = regRequest.writeData;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	valid_delay_a: assert property (sampleValid && !softReset |=>
		outValid) else $error("no output after frame");
	valid_cause_a: assert property (outValid |-> $past(sampleValid))
		else $error("output without frame");
	div_write_a: assert property (wr && adr == 8'h0b |=>
		globalConfig.clockDivide == $past(wd[2:0]))
		else $error("divider not written");
	chop_write_a: assert property (wr && adr == 8'h0c |=>
		globalConfig.chopEnable == $past(wd[2]))
		else $error("chop bit not written");
	format_write_a: assert property (wr && adr == 8'h14 |=>
		globalConfig.reducedRange == $past(wd[6]) &&
		globalConfig.twosComplement == $past(wd[0]))
		else $error("format bits not written");
	tick_gap_a: assert property (dividedClockTick && !wr && !softReset &&
		globalConfig.clockDivide == 3'h2 ##1 (!wr && !softReset) [*2] |->
		!dividedClockTick && !$past(dividedClockTick) ##1 dividedClockTick)
		else $error("tick spacing wrong");
	soft_default_a: assert property (softReset |=>
		globalConfig == 6'h01 && !outValid) else $error("soft reset wrong");
	local_stable_a: assert property (wr && adr inside {8'h0d, 8'h10}
		|=> $stable(globalConfig)) else $error("global bits disturbed");
endmodule
bind adc_output_test_config_regs config_regs_checker i_config_regs_checker
	(.sys_clk, .reset_n, .softReset, .regRequest, .sampleValid,
	.globalConfig, .dividedClockTick, .outValid);
`default_nettype wire

// file: spi_host.sv
// Host model issuing register accesses to the bank
// Assumes one clock; write is a one-cycle strobe, reads are combinational
`timescale 1ns/1ps
`default_nettype none
module spi_host
	import adc_test_config_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic [7:0]     regReadData,
	output var reg_request_type regRequest
);
	initial regRequest = '0;
	task automatic wr(input logic [7:0] a, d, s);
		@(posedge sys_clk);
		regRequest <= '{1'b1, a, d, s};
		@(posedge sys_clk);
		regRequest.write <= 1'b0;
		// Stale data is scrambled so nothing leans on it
		regRequest.writeData <= ~d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, s, output logic [7:0] d);
		@(posedge sys_clk);
		regRequest <= '{1'b0, a, ~regRequest.writeData, s};
		#1 d = regReadData;
	endtask
endmodule
`default_nettype wire

// file: tb_adc_output_test_config_regs.sv
// Self-checking bench for the config register bank
// Assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb_adc_output_test_config_regs;
	import adc_test_config_pkg::*;
	logic              sys_clk;
	logic              reset_n;
	logic              softReset;
	logic              sampleValid;
	logic              dividedClockTick;
	logic              outValid;
	logic [7:0]        regReadData;
	logic [15:0]       userPattern1;
	logic [15:0]       userPattern2;
	reg_request_type   regRequest;
	channel_words_type sampleData;
	channel_words_type outData;
	global_config_type globalConfig;
	int                miscompares;
	int                comparisons;
	spi_host i_spi_host(.sys_clk(sys_clk),
		.regReadData(regReadData), .regRequest(regRequest));
	adc_output_test_config_regs i_adc_output_test_config_regs(.sys_clk,
		.reset_n, .softReset, .regRequest, .regReadData, .userPattern1,
		.userPattern2, .sampleValid, .sampleData, .globalConfig,
		.dividedClockTick, .outValid, .outData);
	task automatic chk(input logic [15:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: want %h got %h", $time, e, g);
		end
	endtask
	task automatic frm(input logic [11:0] s);
		@(posedge sys_clk);
		sampleValid <= 1'b1;
		sampleData <= {8{s}};
		@(posedge sys_clk);
		sampleValid <= 1'b0;
		sampleData <= {8{~s}};
		#1 chk(16'h1, outValid);
	endtask
	task automatic t_defaults();
		logic [7:0] d;
		logic [7:0] a [6] = '{8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h14, 8'h20};
		for (int i = 0; i < 6; i++)
		begin
			i_spi_host.rd(a[i], 8'h01, d);
			chk({15'h0, i == 4}, d);
		end
		i_spi_host.wr(8'h0c, 8'h04, 8'h00);
		chk(16'h1, globalConfig.chopEnable);
		@(posedge sys_clk);
		softReset <= 1'b1;
		@(posedge sys_clk);
		softReset <= 1'b0;
		#1 chk(16'h1, globalConfig);
	endtask
	task automatic t_divider();
		int n;
		for (int k = 0; k < 8; k++)
		begin
			i_spi_host.wr(8'h0b, 8'(k), 8'h00);
			n = 0;
			repeat (8 * (k + 1)) @(negedge sys_clk) n += dividedClockTick;
			chk(16'h8, n[15:0]);
		end
	endtask
	task automatic t_patterns();
		logic [11:0] p [13] = '{12'h0, 12'h800, 12'hfff, 12'h0, 12'h0,
			12'h0, 12'h0, 12'h0, 12'habc, 12'haaa, 12'h03f, 12'h0, 12'ha0f};
		logic [11:0] w;
		for (int c = 1; c < 13; c++)
		begin
			i_spi_host.wr(8'h0d, 8'(c), 8'hff);
			frm(12'h123);
			w = ~outData[7];
			if (13'b1011100001110 >> c & 1) chk(p[c], outData[7]);
			frm(12'h123);
			if (c == 4 || c == 7) chk(w, outData[7]);
			if (c == 11) chk(16'h1, $onehot(outData[7]));
		end
		i_spi_host.wr(8'h0d, 8'h05, 8'hff);
		i_spi_host.wr(8'h0d, 8'h25, 8'h01);
		frm(12'h123);
		frm(12'h123);
		chk(16'hfff, outData[7]);
		i_spi_host.wr(8'h0d, 8'h06, 8'hff);
		i_spi_host.wr(8'h0d, 8'h16, 8'h01);
		frm(12'h123);
		chk(16'hff8, outData[7]);
	endtask
	task automatic t_user();
		logic [11:0] x [4][3] = '{'{12'habc, 12'habc, 12'habc},
			'{12'habc, 12'h456, 12'habc}, '{12'habc, 12'h0, 12'h0},
			'{12'habc, 12'h456, 12'h0}};
		for (int q = 0; q < 4; q++)
		begin
			i_spi_host.wr(8'h0d, {2'(q), 6'h08}, 8'h01);
			for (int f = 0; f < 3; f++)
			begin
				frm(12'h321);
				chk(x[q][f], outData[0]);
			end
		end
	endtask
	task automatic t_trim();
		logic [7:0] d;
		i_spi_host.wr(8'h0d, 8'h00, 8'hff);
		i_spi_host.wr(8'h10, 8'h05, 8'h01);
		i_spi_host.wr(8'h10, 8'h77, 8'h00);
		frm(12'h800);
		chk(16'h005, outData[0]);
		chk(16'h000, outData[1]);
		i_spi_host.wr(8'h14, 8'h44, 8'h01);
		chk(16'h2, {globalConfig.reducedRange, globalConfig.twosComplement});
		frm(12'h800);
		chk(16'h7fa, outData[0]);
		chk(16'h800, outData[1]);
		i_spi_host.wr(8'h10, 8'hfb, 8'h01);
		frm(12'h002);
		chk(16'hfff, outData[0]);
		chk(16'h002, outData[1]);
		i_spi_host.rd(8'h10, 8'h03, d);
		chk(16'hfb, d);
		i_spi_host.rd(8'h14, 8'h01, d);
		chk(16'h44, d);
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial
	begin
		#200us;
		miscompares++;
		print_verdict();
	end
	initial
	begin
		reset_n = 1'b0;
		softReset = 1'b0;
		sampleValid = 1'b0;
		sampleData = '0;
		userPattern1 = 16'habc5;
		userPattern2 = 16'h4561;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_defaults();
		t_divider();
		t_patterns();
		t_user();
		t_trim();
		print_verdict();
	end
endmodule
`default_nettype wire
